// ### include/uart_rx_wake_pkg.sv
// Purpose: Constants and types for the receive, address detect and wake block
// Assumes: 100 MHz system clock, plain register port with 8-bit byte address
// Notes: All registers are 32-bit words, narrow fields sit in the low bits
package uart_rx_wake_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BAUD = 8'h04;
    localparam logic [7:0] ADDR_RXDATA = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_SPEED_BIT = 0;
    localparam int CTRL_ADDR_DET_BIT = 1;
    localparam int CTRL_WAKE_BIT = 2;
    localparam int CTRL_RIE_BIT = 3;
    localparam int CTRL_WIDTH_BIT = 4;
    localparam int CTRL_RXEN_BIT = 5;
    localparam int CTRL_W = 6;
    localparam int BAUD_W = 12;
    localparam int DATA_W = 9;
    localparam int STAT_W = 4;
    localparam int ST_RX_READY = 0;
    localparam int ST_RX_ADDR = 1;
    localparam int ST_WAKE = 2;
    localparam int ST_FRAME_ERR = 3;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;
    localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
    localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
    localparam logic [3:0] BITS_8_LAST = 4'h7;
    localparam logic [3:0] BITS_9_LAST = 4'h8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;

    typedef struct packed {
        logic rx_enable;
        logic data_width_select;
        logic rx_irq_enable;
        logic wake_enable;
        logic address_detect_enable;
        logic baud_speed_select;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : uart_rx_wake_pkg

// ### core/uart_rx_address_wake_ctrl.sv
// Purpose: Receive path with baud speed select, address detect, pin wake and irq gating
// Assumes: Receive pin is asynchronous; clock-off flag comes from the same clock domain
// Notes: One start bit, 8 or 9 data bits LSB first, one stop bit
//
// Operation
// - Baud speed select 1 gives high speed, 0 low speed, with divisor.
// - Address detect on: word is address when its top data bit is 1.
// - Address detect and interrupt on: every address word requests an interrupt.
// - Address detect on: words with address bit 0 are dropped silently.
// - Wake enable set: falling edge on receive pin raises wake-up request.
// - Pin wake acts only while UART clock is off.
// - Enabled wake request interrupts; processor then restarts the UART clock.
// - Receiver interrupt enable passes receiver interrupts at 1, blocks at 0.
// - Width select picks 8 or 9 bits; ninth bit kept read-only.
`timescale 1ns/1ps

module uart_rx_address_wake_ctrl (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_rx_pin,
    input wire logic i_uart_clock_off,
    output logic [31:0] o_rd_data,
    output logic o_irq,
    output logic o_wake_request,
    output logic o_baud_tick
);
    import uart_rx_wake_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        ctrl_t ctrl;
        logic [BAUD_W-1:0] baud_divisor;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic [DATA_W-1:0] rx_data;
        logic [BAUD_W-1:0] div_cnt;
        logic [1:0] pre_cnt;
        logic tick;
        rx_state_t rx_state;
        logic [3:0] os_cnt;
        logic [3:0] bit_idx;
        logic [DATA_W-1:0] shift;
        logic [31:0] rd_data;
        logic irq;
    } state_t;

    localparam state_t STATE_RESET = '{
        rx_meta: 1'b1,
        rx_sync: 1'b1,
        rx_prev: 1'b1,
        ctrl: CTRL_RESET,
        baud_divisor: BAUD_RESET,
        status: '0,
        mask: MASK_RESET,
        rx_data: '0,
        div_cnt: '0,
        pre_cnt: '0,
        tick: 1'b0,
        rx_state: RX_IDLE,
        os_cnt: '0,
        bit_idx: '0,
        shift: '0,
        rd_data: '0,
        irq: 1'b0
    };

    state_t st;
    state_t next_st;
    reg_req_t req;

    assign req = '{addr: i_addr, wdata: i_wr_data, wr: i_wr, rd: i_rd};

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction : hit

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [STAT_W-1:0] set_bits;
    logic [STAT_W-1:0] clr_bits;
    logic [STAT_W-1:0] gate_bits;
    logic fall_edge;
    logic addr_bit;
    logic [3:0] last_bit;
    logic [31:0] rd_mux;

    always_comb begin
        next_st = st;
        set_bits = '0;
        clr_bits = '0;
        addr_bit = 1'b0;
        rd_mux = 32'h0000_0000;

        // Pin synchroniser
        next_st.rx_meta = i_rx_pin;
        next_st.rx_sync = st.rx_meta;
        next_st.rx_prev = st.rx_sync;
        fall_edge = st.rx_prev & ~st.rx_sync;

        // Pin wake only while the UART clock is stopped
        if (st.ctrl.wake_enable && i_uart_clock_off && fall_edge) begin
            set_bits[ST_WAKE] = 1'b1;
        end

        // Baud generator: low speed adds a divide by four
        next_st.tick = 1'b0;
        if (i_uart_clock_off || !st.ctrl.rx_enable) begin
            next_st.div_cnt = '0;
            next_st.pre_cnt = '0;
        end else if (st.div_cnt >= st.baud_divisor) begin
            next_st.div_cnt = '0;
            if (st.ctrl.baud_speed_select) begin
                next_st.tick = 1'b1;
            end else begin
                next_st.pre_cnt = st.pre_cnt + 2'h1;
                next_st.tick = (st.pre_cnt == LOW_SPEED_LAST);
            end
        end else begin
            next_st.div_cnt = st.div_cnt + 12'h001;
        end

        // Receiver, stepped on each oversample tick
        last_bit = st.ctrl.data_width_select ? BITS_9_LAST : BITS_8_LAST;
        if (i_uart_clock_off || !st.ctrl.rx_enable) begin
            next_st.rx_state = RX_IDLE;
            next_st.os_cnt = '0;
        end else if (st.tick) begin
            next_st.os_cnt = st.os_cnt + 4'h1;
            case (st.rx_state)
                RX_IDLE: begin
                    next_st.os_cnt = '0;
                    if (!st.rx_sync) begin
                        next_st.rx_state = RX_START;
                    end
                end
                RX_START: begin
                    if (st.os_cnt == OVERSAMPLE_MID) begin
                        next_st.os_cnt = '0;
                        next_st.bit_idx = '0;
                        next_st.shift = '0;
                        next_st.rx_state = st.rx_sync ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (st.os_cnt == OVERSAMPLE_LAST) begin
                        next_st.shift[st.bit_idx] = st.rx_sync;
                        next_st.bit_idx = st.bit_idx + 4'h1;
                        if (st.bit_idx == last_bit) begin
                            next_st.rx_state = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (st.os_cnt == OVERSAMPLE_LAST) begin
                        next_st.rx_state = RX_IDLE;
                        addr_bit = st.ctrl.data_width_select ? st.shift[8] : st.shift[7];
                        if (!st.rx_sync) begin
                            set_bits[ST_FRAME_ERR] = 1'b1;
                        end else if (st.ctrl.address_detect_enable && !addr_bit) begin
                            next_st.rx_data = st.rx_data;
                        end else begin
                            next_st.rx_data[7:0] = st.shift[7:0];
                            if (st.ctrl.data_width_select) begin
                                next_st.rx_data[8] = st.shift[8];
                            end
                            set_bits[ST_RX_READY] = 1'b1;
                            set_bits[ST_RX_ADDR] = st.ctrl.address_detect_enable;
                        end
                    end
                end
                default: begin
                    next_st.rx_state = RX_IDLE;
                end
            endcase
        end

        // Register writes
        if (req.wr) begin
            if (hit(req, ADDR_CTRL)) begin
                next_st.ctrl = ctrl_t'(req.wdata[CTRL_W-1:0]);
            end
            if (hit(req, ADDR_BAUD)) begin
                next_st.baud_divisor = req.wdata[BAUD_W-1:0];
            end
            if (hit(req, ADDR_STATUS)) begin
                clr_bits = req.wdata[STAT_W-1:0];
            end
            if (hit(req, ADDR_MASK)) begin
                next_st.mask = req.wdata[STAT_W-1:0];
            end
        end
        // Hardware set wins over a same-cycle clear
        next_st.status = (st.status & ~clr_bits) | set_bits;

        // Register reads, data in the following cycle only
        if (req.rd) begin
            case (req.addr)
                ADDR_CTRL: rd_mux = {26'h000_0000, st.ctrl};
                ADDR_BAUD: rd_mux = {20'h0_0000, st.baud_divisor};
                ADDR_RXDATA: rd_mux = {23'h00_0000, st.rx_data};
                ADDR_STATUS: rd_mux = {28'h000_0000, st.status};
                ADDR_MASK: rd_mux = {28'h000_0000, st.mask};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
        next_st.rd_data = rd_mux;

        // Receiver events pass only with the receiver interrupt enable
        gate_bits = '1;
        gate_bits[ST_RX_READY] = st.ctrl.rx_irq_enable;
        gate_bits[ST_RX_ADDR] = st.ctrl.rx_irq_enable;
        gate_bits[ST_FRAME_ERR] = st.ctrl.rx_irq_enable;
        next_st.irq = |(next_st.status & st.mask & gate_bits);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rd_data = st.rd_data;
    assign o_irq = st.irq;
    assign o_wake_request = st.status[ST_WAKE];
    assign o_baud_tick = st.tick;

endmodule : uart_rx_address_wake_ctrl

// ### verification/uart_rx_wake_sva.sv
// Purpose: Port-level checks for the receive, address and wake block
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module uart_rx_wake_sva
    import uart_rx_wake_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_rx_pin,
    input wire logic i_uart_clock_off,
    input wire logic [31:0] o_rd_data,
    input wire logic o_irq,
    input wire logic o_wake_request,
    input wire logic o_baud_tick
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    property p_rd_idle; !i_rd |=> o_rd_data == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_unmapped; i_rd && i_addr > ADDR_MASK |=> o_rd_data == 32'h0; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
    property p_rd_rxdata; i_rd && i_addr == ADDR_RXDATA |=> o_rd_data[31:DATA_W] == '0; endproperty
    a_rd_rxdata: assert property (p_rd_rxdata) else $error("rxdata high bits");
    property p_idle_tick; i_uart_clock_off [*2] |=> !o_baud_tick; endproperty
    a_idle_tick: assert property (p_idle_tick) else $error("tick while clock off");
    property p_wake_clk; $rose(o_wake_request) |-> $past(i_uart_clock_off); endproperty
    a_wake_clk: assert property (p_wake_clk) else $error("wake with clock on");
    // Pin passes two sync stages before status; the edge register holds the prior high level
    property p_wake_pin;
        $rose(o_wake_request) |-> $past(i_rx_pin, 3) == 1'b0 && $past(i_rx_pin, 4) == 1'b1;
    endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("wake without edge");
    property p_wake_hold; o_wake_request && !(i_wr && i_addr == ADDR_STATUS) |=> o_wake_request;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
    property p_irq_fall; $fell(o_irq) |-> $past(i_wr, 2) || $past(i_wr); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule : uart_rx_wake_sva

bind uart_rx_address_wake_ctrl uart_rx_wake_sva chk_i (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .i_rx_pin(i_rx_pin), .i_uart_clock_off(i_uart_clock_off), .o_rd_data(o_rd_data),
    .o_irq(o_irq), .o_wake_request(o_wake_request), .o_baud_tick(o_baud_tick));

// ### verification/serial_node_model.sv
// Purpose: Remote serial node driving the receive line
// Assumes: Line idles high, changes just after a rising edge
// Notes: One start bit, data LSB first, one stop bit
`timescale 1ns/1ps
module serial_node_model (
    input wire logic i_clock,
    output logic o_line
);
    initial o_line = 1'b1;
    task automatic send(input logic [8:0] w, input int nbits, input int bit_cyc);
        @(posedge i_clock);
        o_line <= 1'b0;
        repeat (bit_cyc) @(posedge i_clock);
        for (int i = 0; i < nbits; i++) begin
            o_line <= w[i];
            repeat (bit_cyc) @(posedge i_clock);
        end
        o_line <= 1'b1;
        repeat (bit_cyc) @(posedge i_clock);
    endtask : send
endmodule : serial_node_model

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the receive, address and wake block
// Assumes: Frames at divisor 0, 16 cycles a bit at high speed, 64 at low speed
// Notes: Wake runs with the receiver off
`timescale 1ns/1ps
module tb_top;
    import uart_rx_wake_pkg::*;
    logic i_clock = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_uart_clock_off = 0;
    logic [7:0] i_addr = '0;
    logic [31:0] i_wr_data = '0, o_rd_data;
    logic o_irq, o_wake_request, o_baud_tick, rx_line;
    int error_cnt = 0, compares = 0, n;
    always #5 i_clock = ~i_clock;
    uart_rx_address_wake_ctrl uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .i_rx_pin(rx_line),
        .i_uart_clock_off(i_uart_clock_off), .o_rd_data(o_rd_data), .o_irq(o_irq),
        .o_wake_request(o_wake_request), .o_baud_tick(o_baud_tick));
    serial_node_model node (.i_clock(i_clock), .o_line(rx_line));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(nm, o_rd_data, exp);
    endtask : rdc
    task automatic frame(input logic [8:0] w, input int nbits);
        node.send(w, nbits, 16);
        repeat (20) @(posedge i_clock);
    endtask : frame
    task automatic report_and_stop;
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic t_baud;
        rdc("ctrl", ADDR_CTRL, 32'h0);
        rdc("unmapped", 8'h20, 32'h0);
        wr(ADDR_BAUD, 32'h1);
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_CTRL, 32'h20 | s);
            repeat (4) @(posedge i_clock);
            n = 0;
            repeat (64) begin
                @(posedge i_clock);
                #1 n += o_baud_tick;
            end
            chk("ticks", n, s ? 32 : 8);
        end
        wr(ADDR_BAUD, 32'h0);
    endtask : t_baud
    task automatic t_addr;
        wr(ADDR_MASK, 32'hF);
        wr(ADDR_CTRL, 32'h2B);
        frame(9'h055, 8);
        chk("irq drop", o_irq, 32'h0);
        rdc("status drop", ADDR_STATUS, 32'h0);
        rdc("rxdata drop", ADDR_RXDATA, 32'h0);
        frame(9'h0A5, 8);
        chk("irq addr", o_irq, 32'h1);
        rdc("rxdata", ADDR_RXDATA, 32'hA5);
        rdc("status addr", ADDR_STATUS, 32'h3);
        wr(ADDR_STATUS, 32'h3);
        rdc("status clr", ADDR_STATUS, 32'h0);
        chk("irq clr", o_irq, 32'h0);
        wr(ADDR_CTRL, 32'h3B);
        frame(9'h0FF, 9);
        rdc("status9 drop", ADDR_STATUS, 32'h0);
        frame(9'h123, 9);
        rdc("rxdata9", ADDR_RXDATA, 32'h123);
        wr(ADDR_STATUS, 32'hF);
        wr(ADDR_CTRL, 32'h33);
        frame(9'h1C3, 9);
        chk("irq gated", o_irq, 32'h0);
        rdc("status gated", ADDR_STATUS, 32'h3);
        wr(ADDR_STATUS, 32'hF);
    endtask : t_addr
    task automatic t_plain;
        wr(ADDR_CTRL, 32'h29);
        frame(9'h03C, 8);
        chk("irq data", o_irq, 32'h1);
        rdc("status data", ADDR_STATUS, 32'h1);
        rdc("rxdata8", ADDR_RXDATA, 32'h13C);
        wr(ADDR_STATUS, 32'hF);
        // Ninth bit low lands on the stop slot
        frame(9'h000, 9);
        chk("irq ferr", o_irq, 32'h1);
        rdc("status ferr", ADDR_STATUS, 32'h8);
        rdc("rxdata ferr", ADDR_RXDATA, 32'h13C);
        wr(ADDR_STATUS, 32'hF);
        wr(ADDR_CTRL, 32'h28);
        node.send(9'h05A, 8, 64);
        repeat (20) @(posedge i_clock);
        rdc("rxdata low", ADDR_RXDATA, 32'h15A);
        wr(ADDR_STATUS, 32'hF);
    endtask : t_plain
    task automatic t_wake;
        wr(ADDR_MASK, 32'h4);
        wr(ADDR_CTRL, 32'h4);
        frame(9'h000, 8);
        chk("wake clock on", o_wake_request, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        i_uart_clock_off <= 1'b1;
        frame(9'h000, 8);
        chk("wake disabled", o_wake_request, 32'h0);
        wr(ADDR_CTRL, 32'h4);
        fork
            node.send(9'h000, 8, 16);
            for (n = 0; n < 30 && o_wake_request !== 1'b1; n++) @(posedge i_clock);
        join
        chk("wake", o_wake_request, 32'h1);
        if (n == 30)
            error_cnt++;
        chk("wake irq", o_irq, 32'h1);
        rdc("wake status", ADDR_STATUS, 32'h4);
        @(posedge i_clock) i_uart_clock_off <= 1'b0;
        wr(ADDR_STATUS, 32'h4);
        rdc("wake clr", ADDR_STATUS, 32'h0);
        chk("wake irq clr", o_irq, 32'h0);
    endtask : t_wake

    initial begin
        repeat (5) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_baud;
        t_addr;
        t_plain;
        t_wake;
        report_and_stop;
    end
endmodule : tb_top
